// ===== irq_regs.sv
`timescale 1ns/1ps
module irq_regs
  import tap_cmd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic soft_rst,
  // Events
  input wire logic [IRQ_W-1:0] events,
  // Software access
  input wire logic enable_we,
  input wire logic clear_we,
  input wire logic [IRQ_W-1:0] wdata,
  // State out
  output logic [IRQ_W-1:0] status,
  output logic [IRQ_W-1:0] enable,
  output logic irq
);

  typedef struct packed {
    logic [IRQ_W-1:0] status;
    logic [IRQ_W-1:0] enable;
    logic irq;
  } irq_state_t;

  localparam irq_state_t IRQ_RESET = '0;

  irq_state_t s_q;
  irq_state_t s_d;
  logic [IRQ_W-1:0] status_nx;

  // ==========================================
  // Sticky bits, set beats clear
  for (genvar i = 0; i < IRQ_W; i++) begin : g_bit
    assign status_nx[i] = events[i] | (s_q.status[i] & ~(clear_we & wdata[i]));
  end

  always_comb begin
    s_d = s_q;
    s_d.status = status_nx;
    if (enable_we) begin
      s_d.enable = wdata;
    end
    s_d.irq = |(s_d.status & s_d.enable);
    if (soft_rst) begin
      s_d = IRQ_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= IRQ_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign status = s_q.status;
  assign enable = s_q.enable;
  assign irq = s_q.irq;

endmodule

// ===== opcode_class.sv
`timescale 1ns/1ps
module opcode_class
  import tap_cmd_pkg::*;
(
  // Opcode in
  input wire logic [3:0] op,
  // Class out
  output logic startable,
  output logic uses_counter
);

  // ==========================================
  // Opcode classification
  always_comb begin
    case (op)
      OP_NULL, OP_RESERVED, OP_RSVD_E, OP_RSVD_F: begin
        startable = 1'b0;
        uses_counter = 1'b0;
      end
      OP_STATE_MOVE, OP_STATE_JUMP: begin
        startable = 1'b1;
        uses_counter = 1'b0;
      end
      default: begin
        startable = 1'b1;
        uses_counter = 1'b1;
      end
    endcase
  end

endmodule

// ===== seq_model.sv
`timescale 1ns/1ps
module seq_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Command handshake
  input wire logic start,
  input wire logic [10:0] dly,
  output logic done
);
  logic run;
  logic [10:0] cnt;
  // ==========================================
  // Finish each started command dly+1 cycles after start
  always @(posedge clk) begin
    if (rst) begin
      run <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        run <= 1'b1;
        cnt <= dly;
      end else if (run) begin
        if (cnt == 11'h000) begin
          done <= 1'b1;
          run <= 1'b0;
        end else begin
          cnt <= cnt - 11'h001;
        end
      end
    end
  end
endmodule

// ===== tap_cmd_pkg.sv
package tap_cmd_pkg;

  // ==========================================
  // Register byte offsets
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_COMMAND = 8'h04;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h0C;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h10;

  // ==========================================
  // Status field layout
  localparam int ST_IN_BUF_BIT = 7;
  localparam int ST_OUT_FULL_BIT = 6;
  localparam int ST_CTR_BIT = 5;
  localparam int ST_STATE_W = 4;

  // ==========================================
  // Command field layout
  localparam int CMD_SOFTWARE_FULL_RESET_BIT = 7;
  localparam int CMD_TRST_BIT = 6;
  localparam int OPCODE_W = 4;
  localparam logic [3:0] OP_NULL = 4'h0;
  localparam logic [3:0] OP_RESERVED = 4'h1;
  localparam logic [3:0] OP_STATE_MOVE = 4'h6;
  localparam logic [3:0] OP_STATE_JUMP = 4'h7;
  localparam logic [3:0] OP_RSVD_E = 4'hE;
  localparam logic [3:0] OP_RSVD_F = 4'hF;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic TRST_RESET = 1'b1;

  // ==========================================
  // Interrupt bits
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_DISCARD = 1;
  localparam int IRQ_IN_DATA = 2;

  // ==========================================
  // Stalled command write limit
  localparam int WAIT_LIMIT = 1000;
  localparam int WAIT_W = 10;

  // ==========================================
  // Types
  typedef enum logic [3:0] {
    TS_TEST_LOGIC_RESET, TS_SELECT_DR, TS_CAPTURE_DR, TS_SHIFT_DR,
    TS_EXIT1_DR, TS_PAUSE_DR, TS_EXIT2_DR, TS_UPDATE_DR,
    TS_RUN_TEST_IDLE, TS_SELECT_IR, TS_CAPTURE_IR, TS_SHIFT_IR,
    TS_EXIT1_IR, TS_PAUSE_IR, TS_EXIT2_IR, TS_UPDATE_IR
  } tap_state_t;

  typedef enum logic [1:0] {
    CMD_IDLE, CMD_WAIT_CTR, CMD_RUN
  } cmd_state_t;

endpackage

// ===== tap_master_status_command_regs.sv
`timescale 1ns/1ps
// Overview of operation
// RULE1: Status bit 7 shows input buffer holds data
// RULE2: Status bit 6 shows output buffer full
// RULE3: Bit 5 counter loaded; gates counter commands
// RULE4: State codes 0-7 are reset and DR path; tap_state_t gives code 0 to test-logic-reset
// RULE5: State codes 8-15 are idle and IR path
// RULE6: Status reads are live, never latched
// RULE7: Busy command read returns starting byte
// RULE8: Completion clears opcode to null
// RULE9: Software reset write accepted anytime, resets all
// RULE10: Busy command write stalls ready; abort discards
// RULE11: Command drives reset pin outside discrete mode
// RULE12: Bit 6 zero drives high, one low
// RULE13: Stalled write accepted once command finishes
module tap_master_status_command_regs
  import tap_cmd_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Sequencer status
  input wire logic INPUT_BUFFER_HAS_DATA,
  input wire logic OUTPUT_BUFFER_FULL,
  input wire logic COUNTER_LOADED_FLAG,
  input wire logic [3:0] CURRENT_TARGET_STATE,
  input wire logic DISCRETE_MODE,
  input wire logic CMD_DONE,
  // Sequencer control
  output logic CMD_START,
  output logic [7:0] CMD_BYTE,
  output logic CMD_BUSY,
  output logic SOFT_RESET,
  output logic TRST_OUT,
  // Interrupt
  output logic IRQ
);

  typedef struct packed {
    cmd_state_t st;
    logic [7:0] cmd;
    logic busy;
    logic trst;
    logic start;
    logic soft_rst;
    logic ready;
    logic slverr;
    logic [31:0] rdata;
    logic [WAIT_W-1:0] wait_cnt;
    logic done_ev;
    logic discard_ev;
    logic in_prev;
  } top_state_t;

  localparam top_state_t TOP_RESET = '{
    st: CMD_IDLE, cmd: CMD_RESET, busy: 1'b0, trst: TRST_RESET, start: 1'b0,
    soft_rst: 1'b0, ready: 1'b0, slverr: 1'b0, rdata: 32'h0000_0000,
    wait_cnt: '0, done_ev: 1'b0, discard_ev: 1'b0, in_prev: 1'b0
  };

  top_state_t s_q;
  top_state_t s_d;

  logic access;
  logic cmd_wr;
  logic software_full_reset_wr;
  logic cmd_rd;
  logic cur_busy;
  logic finishing;
  logic wr_start;
  logic wr_uses_ctr;
  logic cur_uses_ctr;
  logic [7:0] status_byte;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_enable;
  logic [IRQ_W-1:0] irq_events;
  logic irq_en_we;
  logic irq_clr_we;

  // ==========================================
  // Bus decode
  assign access = PSEL & PENABLE & ~s_q.ready;
  assign cmd_wr = access & PWRITE & (PADDR == OFF_COMMAND);
  assign software_full_reset_wr = cmd_wr & PWDATA[CMD_SOFTWARE_FULL_RESET_BIT];
  assign cmd_rd = access & ~PWRITE & (PADDR == OFF_COMMAND);
  assign irq_en_we = access & PWRITE & (PADDR == OFF_IRQ_ENABLE);
  assign irq_clr_we = access & PWRITE & (PADDR == OFF_IRQ_CLEAR);
  assign cur_busy = (s_q.st != CMD_IDLE);
  assign finishing = (s_q.st == CMD_RUN) & CMD_DONE;

  // ==========================================
  // Live status byte
  assign status_byte = {
    INPUT_BUFFER_HAS_DATA,  // RULE1 RULE6
    OUTPUT_BUFFER_FULL,     // RULE2
    COUNTER_LOADED_FLAG,    // RULE3
    1'b0,
    CURRENT_TARGET_STATE    // RULE4 RULE5
  };

  opcode_class u_wr_class (
    .op(PWDATA[OPCODE_W-1:0]),
    .startable(wr_start),
    .uses_counter(wr_uses_ctr)
  );

  opcode_class u_cur_class (
    .op(s_q.cmd[OPCODE_W-1:0]),
    .startable(),
    .uses_counter(cur_uses_ctr)
  );

  // ==========================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.start = 1'b0;
    s_d.soft_rst = 1'b0;
    s_d.ready = 1'b0;
    s_d.slverr = 1'b0;
    s_d.done_ev = 1'b0;
    s_d.discard_ev = 1'b0;
    s_d.wait_cnt = '0;
    s_d.in_prev = INPUT_BUFFER_HAS_DATA;
    // Command sequencing
    case (s_q.st)
      CMD_IDLE: begin
      end
      CMD_WAIT_CTR: begin
        if (COUNTER_LOADED_FLAG) begin // RULE3
          s_d.st = CMD_RUN;
          s_d.start = 1'b1;
        end
      end
      CMD_RUN: begin
        if (CMD_DONE) begin
          s_d.st = CMD_IDLE;
          s_d.cmd[OPCODE_W-1:0] = OP_NULL; // RULE8
          s_d.done_ev = 1'b1;
        end
      end
      default: begin
        s_d.st = CMD_IDLE;
      end
    endcase
    // Bus access
    if (access) begin
      if (software_full_reset_wr) begin
        s_d = TOP_RESET; // RULE9
        s_d.soft_rst = 1'b1;
        s_d.ready = 1'b1;
      end else if (cmd_wr && cur_busy && !finishing) begin
        s_d.wait_cnt = s_q.wait_cnt + 1'b1; // RULE10
        if (s_q.wait_cnt == WAIT_W'(WAIT_LIMIT - 1)) begin
          s_d.ready = 1'b1;
          s_d.slverr = 1'b1;
          s_d.discard_ev = 1'b1;
          s_d.wait_cnt = '0;
        end
      end else if (cmd_wr) begin
        s_d.ready = 1'b1; // RULE13
        if (!DISCRETE_MODE) begin
          s_d.trst = ~PWDATA[CMD_TRST_BIT]; // RULE11 RULE12
        end
        if (wr_start) begin
          s_d.cmd = PWDATA[7:0];
          if (wr_uses_ctr && !COUNTER_LOADED_FLAG) begin
            s_d.st = CMD_WAIT_CTR; // RULE3
          end else begin
            s_d.st = CMD_RUN;
            s_d.start = 1'b1;
          end
        end else begin
          s_d.cmd = {PWDATA[7:OPCODE_W], OP_NULL};
          s_d.st = CMD_IDLE;
        end
      end else begin
        s_d.ready = 1'b1;
        s_d.rdata = 32'h0000_0000;
        case (PADDR)
          OFF_STATUS: s_d.rdata[7:0] = status_byte; // RULE6
          OFF_COMMAND: s_d.rdata[7:0] = s_q.cmd; // RULE7
          OFF_IRQ_STATUS: s_d.rdata[IRQ_W-1:0] = irq_status;
          OFF_IRQ_ENABLE: s_d.rdata[IRQ_W-1:0] = irq_enable;
          OFF_IRQ_CLEAR: s_d.rdata = 32'h0000_0000;
          default: s_d.slverr = 1'b1;
        endcase
        if (PWRITE) begin
          s_d.rdata = 32'h0000_0000;
          s_d.slverr = (PADDR == OFF_STATUS) || (PADDR == OFF_IRQ_STATUS) ||
                       !((PADDR == OFF_IRQ_ENABLE) || (PADDR == OFF_IRQ_CLEAR));
        end
      end
    end
    s_d.busy = (s_d.st != CMD_IDLE);
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      s_q <= TOP_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================
  // Interrupts
  assign irq_events[IRQ_DONE] = s_q.done_ev;
  assign irq_events[IRQ_DISCARD] = s_q.discard_ev;
  assign irq_events[IRQ_IN_DATA] = INPUT_BUFFER_HAS_DATA & ~s_q.in_prev;

  irq_regs u_irq (
    .clk(MCLK),
    .rst(SYS_RST),
    .soft_rst(s_q.soft_rst),
    .events(irq_events),
    .enable_we(irq_en_we),
    .clear_we(irq_clr_we),
    .wdata(PWDATA[IRQ_W-1:0]),
    .status(irq_status),
    .enable(irq_enable),
    .irq(IRQ)
  );

  assign PRDATA = s_q.rdata;
  assign PREADY = s_q.ready;
  assign PSLVERR = s_q.slverr;
  assign CMD_START = s_q.start;
  assign CMD_BYTE = s_q.cmd;
  assign CMD_BUSY = s_q.busy;
  assign SOFT_RESET = s_q.soft_rst;
  assign TRST_OUT = s_q.trst;

  // ==========================================
  // Checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  logic status_rd;
  assign status_rd = access & ~PWRITE & (PADDR == OFF_STATUS);

  a_status_in_buf: assert property ( // RULE1
    status_rd |=> PREADY && (PRDATA[ST_IN_BUF_BIT] == $past(INPUT_BUFFER_HAS_DATA)))
    else $error("input buffer flag wrong");
  a_status_out_full: assert property ( // RULE2
    status_rd |=> PRDATA[ST_OUT_FULL_BIT] == $past(OUTPUT_BUFFER_FULL))
    else $error("output buffer flag wrong");
  a_ctr_gates_start: assert property ( // RULE3
    CMD_START |-> !cur_uses_ctr || $past(COUNTER_LOADED_FLAG))
    else $error("counter command started unloaded");
  a_state_dr_code: assert property ( // RULE4
    status_rd |=> PRDATA[2:0] == $past(CURRENT_TARGET_STATE[2:0]))
    else $error("state low bits wrong");
  a_state_ir_code: assert property ( // RULE5
    status_rd |=> PRDATA[3] == $past(CURRENT_TARGET_STATE[3]) && PRDATA[4] == 1'b0)
    else $error("state high bit wrong");
  a_status_live: assert property ( // RULE6
    status_rd |=> PREADY && PRDATA[ST_CTR_BIT] == $past(COUNTER_LOADED_FLAG))
    else $error("counter flag stale");
  a_busy_readback: assert property ( // RULE7
    (cmd_rd && CMD_BUSY) |=> PRDATA[7:0] == $past(CMD_BYTE))
    else $error("busy readback wrong");
  a_done_nulls_op: assert property ( // RULE8
    (finishing && !cmd_wr) |=> !CMD_BUSY && CMD_BYTE[OPCODE_W-1:0] == OP_NULL)
    else $error("opcode not nulled");
  a_software_full_reset_anytime: assert property ( // RULE9
    software_full_reset_wr |=> PREADY && SOFT_RESET && !CMD_BUSY && CMD_BYTE == CMD_RESET ##1 !SOFT_RESET)
    else $error("software reset not taken");
  a_busy_write_stall: assert property ( // RULE10
    (cmd_wr && !software_full_reset_wr && cur_busy && !finishing) |=>
      (!PREADY || PSLVERR) && CMD_BYTE == $past(CMD_BYTE))
    else $error("busy write not stalled");
  a_trst_discrete: assert property ( // RULE11
    (cmd_wr && !software_full_reset_wr && DISCRETE_MODE) |=> $stable(TRST_OUT))
    else $error("reset pin moved in discrete mode");
  a_trst_level: assert property ( // RULE12
    (cmd_wr && !software_full_reset_wr && !DISCRETE_MODE && (!cur_busy || finishing)) |=>
      TRST_OUT == !$past(PWDATA[CMD_TRST_BIT]))
    else $error("reset pin level wrong");
  a_stall_accept: assert property ( // RULE13
    (cmd_wr && !software_full_reset_wr && finishing) |=> PREADY && !PSLVERR)
    else $error("stalled write not accepted");

  c_stall_then_accept: cover property (
    (cmd_wr && cur_busy && !finishing) ##1 (cmd_wr && finishing));
  c_discard: cover property (s_q.discard_ev);
  c_software_full_reset_busy: cover property (software_full_reset_wr && cur_busy);
  c_wait_ctr: cover property (s_q.st == CMD_WAIT_CTR ##1 CMD_START);

endmodule

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import tap_cmd_pkg::*;
  logic MCLK = 0, SYS_RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  logic PREADY, PSLVERR, CMD_START, CMD_BUSY, SOFT_RESET, TRST_OUT, IRQ, CMD_DONE;
  logic INPUT_BUFFER_HAS_DATA = 0, OUTPUT_BUFFER_FULL = 0, COUNTER_LOADED_FLAG = 1;
  logic DISCRETE_MODE = 0;
  logic [3:0] CURRENT_TARGET_STATE = 4'h0;
  logic [7:0] CMD_BYTE;
  logic [10:0] dly = 11'h01E;
  logic [31:0] rd;
  logic err;
  int n_fail = 0, checked = 0, n_start = 0, cyc = 0, n_srst = 0;
  tap_master_status_command_regs dut (.MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .INPUT_BUFFER_HAS_DATA(INPUT_BUFFER_HAS_DATA),
    .OUTPUT_BUFFER_FULL(OUTPUT_BUFFER_FULL), .COUNTER_LOADED_FLAG(COUNTER_LOADED_FLAG),
    .CURRENT_TARGET_STATE(CURRENT_TARGET_STATE), .DISCRETE_MODE(DISCRETE_MODE),
    .CMD_DONE(CMD_DONE), .CMD_START(CMD_START), .CMD_BYTE(CMD_BYTE), .CMD_BUSY(CMD_BUSY),
    .SOFT_RESET(SOFT_RESET), .TRST_OUT(TRST_OUT), .IRQ(IRQ));
  seq_model seq (.clk(MCLK), .rst(SYS_RST | SOFT_RESET), .start(CMD_START), .dly(dly),
    .done(CMD_DONE));
  // ==========================================
  // Clock, start counter and timeout
  initial begin
    forever #20 MCLK = ~MCLK;
  end
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (CMD_START === 1'b1) n_start <= n_start + 1;
    if (SOFT_RESET === 1'b1) n_srst <= n_srst + 1;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  // ==========================================
  // Shared tasks
  task tick(input int n);
    repeat (n) @(posedge MCLK);
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge MCLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge MCLK);
  endtask
  task wait_idle();
    while (CMD_BUSY !== 1'b0) @(posedge MCLK);
  endtask
  // ==========================================
  // Scenarios
  task t_status();
    for (int i = 0; i < 16; i++) begin
      INPUT_BUFFER_HAS_DATA <= i[0];
      OUTPUT_BUFFER_FULL <= i[1];
      COUNTER_LOADED_FLAG <= i[2];
      CURRENT_TARGET_STATE <= i[3:0];
      apb(1'b0, OFF_STATUS, 32'h0);
      chk("status", {24'h0, i[0], i[1], i[2], 1'b0, i[3:0]}, rd);
    end
    COUNTER_LOADED_FLAG <= 1'b1;
  endtask
  task t_cmd();
    apb(1'b1, OFF_COMMAND, 32'h49);
    tick(1);
    chk("trst", 32'h0, {31'h0, TRST_OUT});
    apb(1'b0, OFF_COMMAND, 32'h0);
    chk("cmd busy", 32'h49, rd);
    wait_idle();
    apb(1'b0, OFF_COMMAND, 32'h0);
    chk("cmd done", 32'h40, rd);
  endtask
  task t_ctr();
    int s;
    COUNTER_LOADED_FLAG <= 1'b0;
    s = n_start;
    apb(1'b1, OFF_COMMAND, 32'h02);
    tick(8);
    chk("no start", s, n_start);
    COUNTER_LOADED_FLAG <= 1'b1;
    tick(4);
    chk("start", s + 1, n_start);
    wait_idle();
  endtask
  task t_stall();
    apb(1'b1, OFF_COMMAND, 32'h09);
    apb(1'b1, OFF_COMMAND, 32'h06);
    chk("stall err", 32'h0, {31'h0, err});
    apb(1'b0, OFF_COMMAND, 32'h0);
    chk("next cmd", 32'h06, rd);
    wait_idle();
  endtask
  task t_abort();
    dly <= 11'h44C;
    apb(1'b1, OFF_COMMAND, 32'h0B);
    apb(1'b1, OFF_COMMAND, 32'h4B);
    chk("abort err", 32'h1, {31'h0, err});
    wait_idle();
    apb(1'b0, OFF_COMMAND, 32'h0);
    chk("discarded", 32'h00, rd);
    chk("trst kept", 32'h1, {31'h0, TRST_OUT});
    apb(1'b0, OFF_IRQ_STATUS, 32'h0);
    chk("irq status", 32'h7, rd);
  endtask
  task t_software_full_reset();
    apb(1'b1, OFF_COMMAND, 32'h49);
    apb(1'b1, OFF_COMMAND, 32'h80);
    chk("software_full_reset err", 32'h0, {31'h0, err});
    tick(2);
    chk("software_full_reset", 32'h1, {22'h0, CMD_BYTE, CMD_BUSY, TRST_OUT});
    chk("software_full_reset pulse", 32'h1, n_srst);
    apb(1'b1, OFF_COMMAND, 32'h3E);
    apb(1'b0, OFF_COMMAND, 32'h0);
    chk("reserved op", 32'h30, rd);
    chk("reserved idle", 32'h0, {31'h0, CMD_BUSY});
    dly <= 11'h01E;
  endtask
  task t_disc_irq();
    DISCRETE_MODE <= 1'b1;
    apb(1'b1, OFF_IRQ_ENABLE, 32'h1);
    apb(1'b1, OFF_COMMAND, 32'h46);
    wait_idle();
    tick(3);
    chk("disc trst", 32'h1, {31'h0, TRST_OUT});
    chk("irq on", 32'h1, {31'h0, IRQ});
    apb(1'b0, OFF_IRQ_ENABLE, 32'h0);
    chk("irq enable", 32'h1, rd);
    apb(1'b1, OFF_IRQ_CLEAR, 32'h1);
    tick(2);
    chk("irq off", 32'h0, {31'h0, IRQ});
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    DISCRETE_MODE <= 1'b0;
  endtask
  // ==========================================
  // Verdict
  task print_verdict();
    if (n_fail == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    tick(20);
    SYS_RST <= 1'b0;
    tick(1);
    t_status();
    t_cmd();
    t_ctr();
    t_stall();
    t_abort();
    t_software_full_reset();
    t_disc_irq();
    print_verdict();
  end
endmodule
